// ===== core/aclk_codec_access_power.sv
// Purpose: codec end of the ac-link: register access, link halt, wake-up
// Assumes: this end makes the bit clock; sync and serial out come from the controller
// Notes:   software sees control and status over axi4-lite
// How it works
// (RULE1) controller primary read: valid, address, id zero
// (RULE2) controller primary write: valid, address, data tags
// (RULE3) secondary access: tags clear, id nonzero
// (RULE4) secondary: matching id marks valid command
// (RULE5) secondary: slot 1 read/write bit gates write
// (RULE6) frame without frame-valid is discarded whole
// (RULE7) controller sets frame-valid on secondary access
// (RULE8) next input frame returns tagged status, id zero
// (RULE9) slot 0 bits 12-3 slot valids, bit 2 zero
// (RULE10) id zero primary, one or two secondary
// (RULE11) halt write stops bit clock and serial in
// (RULE12) controller marks only slots 1, 2 valid
// (RULE13) controller drops sync and serial out afterwards
// (RULE14) controller programs line rate before sleep
// (RULE15) registers kept through power-down modes
// (RULE16) controller waits four frames before sync
// (RULE17) codec-ready bit set when link resumes
// (RULE18) reset pin low: active; rising edge: defaults
// (RULE19) warm reset: sync high one microsecond, halted
// (RULE20) sync framed when clocked, async when halted
// (RULE21) bit clock restarts only after sync low
// (RULE22) wake mask lets ring signal while halted
// (RULE23) halt bit inhibits slot 5 tag
// (RULE24) codec-ready held zero until software ready
// (RULE25) secondary ignores id zero or mismatch
// (RULE26) clock stays halted until cold or warm reset
`timescale 1ns/10ps
module aclk_codec_access_power
  import aclk_pkg::*;
#(
  parameter int WARM_CYCLES = WARM_CYC,
  parameter int BCLK_HALF_CYC = BCLK_HALF
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // ac-link
  input  wire logic        link_reset_n_in,
  input  wire logic        sync_in,
  input  wire logic        sdata_out_in,
  output logic             bit_clk_out,
  output logic             sdata_in_out,
  // straps and events
  input  wire logic        codec_id_select_low_in,
  input  wire logic        codec_id_select_high_in,
  input  wire logic        ring_detect_in,
  // axi4-lite write
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  // axi4-lite read
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out
);
  localparam logic [15:0] WARM_END = 16'(WARM_CYCLES - 1);

  logic          link_ok;
  logic          link_rst;
  logic          rst_src;
  logic [4:0]    pins_s;
  logic          sync_s;
  logic          sdo_s;
  logic          ring_s;
  logic [1:0]    id_s;
  logic          rise_en;
  logic          fall_en;
  logic          run;
  aclk_link_st_t st_r;
  logic [15:0]   warm_cnt_r;
  logic [1:0]    my_id_r;
  logic          id_done_r;
  logic          sync_prev_r;
  logic          frame_act_r;
  logic [7:0]    pos_r;
  logic [19:0]   sh_r;
  logic [19:0]   word;
  logic [15:0]   tag_r;
  logic [19:0]   s1_r;
  logic          start;
  logic [7:0]    pos_nxt;
  logic          decode;
  logic          primary;
  logic          acc;
  logic          wr;
  logic          wr_go;
  logic          set_halt;
  logic          resp_pend_r;
  logic          resp_now_r;
  logic [6:0]    resp_idx_r;
  logic [15:0]   resp_dat_r;
  logic [15:0]   rd_data;
  logic [15:0]   rate1_r;
  logic [15:0]   rate2_r;
  logic [15:0]   wake_r;
  logic [15:0]   misc_r;
  logic [5:0]    pwr_r;
  logic          codec_ready;
  logic          wake;
  logic [15:0]   tx_tag;
  logic          sdi_r;
  logic          ctl_ready_r;
  logic          ctl_s5_r;
  logic          last_wr_r;
  logic [15:0]   last_dat_r;
  logic          aw_full_r;
  logic          w_full_r;
  logic [7:0]    aw_addr_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;

  // reset pin asserts at once, releases through the synchroniser
  assign rst_src  = sys_rst_in || !link_reset_n_in; // RULE18
  aclk_sync2 #(.W(1)) u_rst (
    .clk_in (clk_in),
    .rst_in (rst_src),
    .d_in   (1'b1),
    .q_out  (link_ok)
  );
  assign link_rst = !link_ok;

  aclk_sync2 #(.W(5)) u_pins (
    .clk_in (clk_in),
    .rst_in (sys_rst_in),
    .d_in   ({sync_in, sdata_out_in, ring_detect_in,
              codec_id_select_high_in, codec_id_select_low_in}),
    .q_out  (pins_s)
  );
  assign sync_s = pins_s[4];
  assign sdo_s  = pins_s[3];
  assign ring_s = pins_s[2];
  assign id_s   = pins_s[1:0];

  // clock keeps running during a reset-pin reset so the controller sees an active link
  assign run = (st_r == ST_RUN);
  aclk_clkgen #(.HALF(BCLK_HALF_CYC)) u_clk (
    .clk_in      (clk_in),
    .rst_in      (sys_rst_in),
    .run_in      (run),
    .bit_clk_out (bit_clk_out),
    .rise_en_out (rise_en),
    .fall_en_out (fall_en)
  );

  // strap caught once after reset release
  always_ff @(posedge clk_in or posedge link_rst) begin
    if (link_rst) begin
      my_id_r   <= 2'h0;
      id_done_r <= 1'b0;
    end else if (!id_done_r) begin
      my_id_r   <= id_s;
      id_done_r <= 1'b1;
    end
  end

  // frame tracking on falling bit clock edges
  assign start   = fall_en && sync_s && !sync_prev_r; // RULE20
  assign pos_nxt = start ? 8'h00 : pos_r + 8'h01;
  assign word    = {sh_r[18:0], sdo_s};

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync_prev_r <= 1'b0;
      frame_act_r <= 1'b0;
      pos_r       <= 8'h00;
      sh_r        <= 20'h00000;
      tag_r       <= 16'h0000;
      s1_r        <= 20'h00000;
    end else if (fall_en) begin
      sync_prev_r <= sync_s;
      sh_r        <= word;
      if (start || frame_act_r) begin
        pos_r       <= pos_nxt;
        frame_act_r <= (pos_nxt != POS_LAST);
      end
      if ((start || frame_act_r) && pos_nxt == POS_TAG_END) begin
        tag_r <= word[15:0];
      end
      if (frame_act_r && pos_nxt == POS_S1_END) begin
        s1_r <= word;
      end
    end
  end

  // command decode at the last bit of slot 2
  assign decode  = fall_en && frame_act_r && pos_nxt == POS_S2_END;
  assign primary = (my_id_r == 2'h0); // RULE10
  always_comb begin
    acc = 1'b0;
    wr  = 1'b0;
    if (tag_r[TAG_FRAME]) begin // RULE6
      if (primary) begin
        acc = tag_r[TAG_ADDR] && tag_r[1:0] == 2'h0;
        wr  = tag_r[TAG_DATA];
      end else begin
        acc = (tag_r[1:0] == my_id_r); // RULE4 RULE25
        wr  = !s1_r[S1_RW]; // RULE5
      end
    end
  end
  assign wr_go    = decode && acc && wr && id_done_r;
  assign set_halt = wr_go && s1_r[18:12] == IDX_MISC && word[4 + HALT_BIT]; // RULE11

  // link registers: only system reset, the reset pin or the reset register restore defaults
  always_ff @(posedge clk_in or posedge link_rst) begin
    if (link_rst) begin
      rate1_r <= RATE_DEF; // RULE18
      rate2_r <= RATE_DEF;
      wake_r  <= WAKE_DEF;
      misc_r  <= MISC_DEF;
      pwr_r   <= PWR_DEF;
    end else if (wr_go) begin
      unique case (s1_r[18:12])
        IDX_RESET: begin // RULE15
          rate1_r <= RATE_DEF;
          rate2_r <= RATE_DEF;
          wake_r  <= WAKE_DEF;
          misc_r  <= MISC_DEF;
          pwr_r   <= PWR_DEF;
        end
        IDX_RATE1: rate1_r <= word[19:4];
        IDX_RATE2: rate2_r <= word[19:4];
        IDX_WAKE:  wake_r  <= word[19:4] & WAKE_MASK;
        IDX_MISC:  misc_r  <= word[19:4] & MISC_MASK;
        IDX_MSTAT: pwr_r   <= word[4 + PWR_MSB:4 + PWR_LSB];
        default:   ;
      endcase
    end
  end

  assign codec_ready = ctl_ready_r && run && id_done_r; // RULE17 RULE24
  always_comb begin
    unique case (resp_idx_r)
      IDX_MID:   rd_data = {my_id_r, 12'h000, my_id_r == 2'h2, my_id_r == 2'h1};
      IDX_MSTAT: rd_data = {2'h3, pwr_r, codec_ready ? READY_ALL : 8'h00};
      IDX_RATE1: rd_data = rate1_r;
      IDX_RATE2: rd_data = rate2_r;
      IDX_WAKE:  rd_data = wake_r;
      IDX_MISC:  rd_data = misc_r;
      default:   rd_data = 16'h0000;
    endcase
  end

  // status goes out in the frame after the access
  always_ff @(posedge clk_in or posedge link_rst) begin
    if (link_rst) begin
      resp_pend_r <= 1'b0;
      resp_now_r  <= 1'b0;
      resp_idx_r  <= 7'h00;
      resp_dat_r  <= 16'h0000;
    end else if (decode) begin
      resp_pend_r <= acc && id_done_r;
      resp_idx_r  <= acc ? s1_r[18:12] : resp_idx_r;
    end else if (start) begin
      resp_now_r  <= resp_pend_r; // RULE8
      resp_pend_r <= 1'b0;
      resp_dat_r  <= resp_pend_r ? rd_data : 16'h0000;
    end
  end

  function automatic logic tx_sel(input logic [7:0] p, input logic [15:0] t,
                                  input logic [19:0] s1, input logic [19:0] s2);
    logic [7:0] d;
    d = 8'h00;
    if (p <= POS_TAG_END) begin
      d = POS_TAG_END - p;
      return t[d[3:0]];
    end else if (p <= POS_S1_END) begin
      d = POS_S1_END - p;
      return s1[d[4:0]];
    end else if (p <= POS_S2_END) begin
      d = POS_S2_END - p;
      return s2[d[4:0]];
    end
    return 1'b0;
  endfunction

  // slot 5 tag drops once a halt is pending or the adc is off; id field stays zero
  always_comb begin
    tx_tag            = 16'h0000;
    tx_tag[TAG_FRAME] = codec_ready;
    tx_tag[TAG_ADDR]  = resp_now_r; // RULE8
    tx_tag[TAG_DATA]  = resp_now_r;
    tx_tag[TAG_S5]    = ctl_s5_r && !misc_r[HALT_BIT] && !pwr_r[PWR_ADC1]; // RULE23 RULE9
  end

  assign wake = (st_r == ST_HALT) && ring_s && wake_r[WAKE_RI1]; // RULE22
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sdi_r <= 1'b0;
    end else if (set_halt || !run) begin
      sdi_r <= wake; // RULE11
    end else if (rise_en) begin
      sdi_r <= frame_act_r &&
               tx_sel(pos_r, tx_tag, {1'b0, resp_idx_r & {7{resp_now_r}}, 12'h000},
                      {resp_dat_r, 4'h0});
    end
  end
  assign sdata_in_out = sdi_r;

  // halt and warm-reset sequencing
  always_ff @(posedge clk_in or posedge link_rst) begin
    if (link_rst) begin
      st_r       <= ST_RUN; // RULE26
      warm_cnt_r <= 16'h0000;
    end else begin
      unique case (st_r)
        ST_RUN: begin
          warm_cnt_r <= 16'h0000;
          if (set_halt) st_r <= ST_HALT; // RULE11
        end
        ST_HALT: begin
          warm_cnt_r <= sync_s ? warm_cnt_r + 16'h0001 : 16'h0000; // RULE20
          if (sync_s && warm_cnt_r == WARM_END) st_r <= ST_WAIT; // RULE19
        end
        ST_WAIT: begin
          if (!sync_s) st_r <= ST_RUN; // RULE21 RULE26
        end
      endcase
    end
  end

  // axi4-lite slave: address and data taken in either order
  assign s_axi_awready_out = !aw_full_r && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_full_r && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_full_r        <= 1'b0;
      w_full_r         <= 1'b0;
      aw_addr_r        <= 8'h00;
      w_data_r         <= 32'h00000000;
      w_strb_r         <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
      ctl_ready_r      <= 1'b0;
      ctl_s5_r         <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end
      if (aw_full_r && w_full_r) begin
        aw_full_r        <= 1'b0;
        w_full_r         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (aw_addr_r == OFS_CTRL) ? RESP_OKAY : RESP_SLV;
        if (aw_addr_r == OFS_CTRL && w_strb_r[0]) begin
          ctl_ready_r <= w_data_r[0]; // RULE24
          ctl_s5_r    <= w_data_r[1];
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      last_wr_r  <= 1'b0;
      last_dat_r <= 16'h0000;
    end else if (decode && acc) begin
      last_wr_r  <= wr;
      last_dat_r <= word[19:4];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= RESP_OKAY;
      unique case (s_axi_araddr_in)
        OFS_CTRL: s_axi_rdata_out <= {30'h0, ctl_s5_r, ctl_ready_r};
        OFS_STAT: s_axi_rdata_out <= {17'h0, resp_idx_r, 3'h0, link_rst,
                                      st_r == ST_WAIT, codec_ready, !run, my_id_r == 2'h0};
        OFS_LAST: s_axi_rdata_out <= {15'h0, last_wr_r, last_dat_r};
        default: begin
          s_axi_rdata_out <= 32'h00000000;
          s_axi_rresp_out <= RESP_SLV;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  chk_halt_clk_low: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE11
    set_halt |=> ##1 (!bit_clk_out && !rise_en) [*4]) else $error("clock not parked on halt");
  chk_frame_drop: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE6
    decode && !tag_r[TAG_FRAME] |=> !resp_pend_r) else $error("invalid frame accepted");
  chk_sec_match: assert property (@(posedge clk_in) disable iff (link_rst) // RULE4
    decode && id_done_r && !primary && tag_r[TAG_FRAME] && tag_r[1:0] == my_id_r
    |=> resp_pend_r) else $error("secondary access missed");
  chk_sec_reject: assert property (@(posedge clk_in) disable iff (link_rst) // RULE25
    decode && !primary && tag_r[1:0] != my_id_r |=> !resp_pend_r) else $error("foreign id taken");
  chk_sec_read: assert property (@(posedge clk_in) disable iff (link_rst) // RULE5
    decode && !primary && s1_r[S1_RW] |=> $stable({rate1_r, rate2_r, wake_r, misc_r, pwr_r}))
    else $error("secondary read wrote");
  chk_resp_tag: assert property (@(posedge clk_in) disable iff (link_rst) // RULE8
    rise_en && run && frame_act_r && resp_now_r && pos_r == 8'h01 |=> sdi_r)
    else $error("status tag missing");
  chk_ready_bit: assert property (@(posedge clk_in) disable iff (link_rst) // RULE17
    rise_en && run && frame_act_r && pos_r == 8'h00 |=> sdi_r == $past(codec_ready))
    else $error("codec ready bit wrong");
  chk_slot5_inhib: assert property (@(posedge clk_in) disable iff (link_rst) // RULE23
    rise_en && run && frame_act_r && pos_r == POS_TAG_S5 && misc_r[HALT_BIT] |=> !sdi_r)
    else $error("slot 5 tag during halt");
  chk_regs_keep: assert property (@(posedge clk_in) disable iff (link_rst) // RULE15
    !run |=> $stable({rate1_r, rate2_r, wake_r, misc_r, pwr_r})) else $error("regs lost");
  chk_warm_len: assert property (@(posedge clk_in) disable iff (link_rst) // RULE19
    st_r == ST_HALT ##1 st_r == ST_WAIT |-> $past(warm_cnt_r) == WARM_END)
    else $error("warm reset too short");
  chk_sync_low: assert property (@(posedge clk_in) disable iff (link_rst) // RULE21
    st_r == ST_WAIT && sync_s |=> !run) else $error("clock restarted with sync high");
  chk_wake_sig: assert property (@(posedge clk_in) disable iff (link_rst) // RULE22
    wake && !set_halt |=> sdi_r) else $error("wake event not signalled");
  chk_cold_run: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE18
    link_rst |=> st_r == ST_RUN) else $error("cold reset left link halted");

  cov_access: cover property (@(posedge clk_in) disable iff (link_rst) decode && acc);
  cov_halt: cover property (@(posedge clk_in) disable iff (link_rst) set_halt);
  cov_warm: cover property (@(posedge clk_in) disable iff (link_rst)
    st_r == ST_WAIT ##1 st_r == ST_RUN);
endmodule

// ===== core/aclk_pkg.sv
// Purpose: shared constants for the codec-side ac-link access and power block
// Assumes: 200 MHz core clock, ac-link frames of 256 bit times
// Notes:   link register indices are 7-bit, as carried in output slot 1
package aclk_pkg;
  // core clock and link timing
  localparam int          CLK_NS    = 5;
  localparam int          WARM_NS   = 1000;
  localparam int          WARM_CYC  = (WARM_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] WARM_LAST = 16'(WARM_CYC - 1);
  localparam int          BCLK_HALF = 6;
  // bit positions inside a frame (last bit of slots 0, 1 and 2, last bit of the frame, slot 5 tag bit)
  localparam logic [7:0]  POS_TAG_END = 8'h0f;
  localparam logic [7:0]  POS_S1_END  = 8'h23;
  localparam logic [7:0]  POS_S2_END  = 8'h37;
  localparam logic [7:0]  POS_LAST    = 8'hff;
  localparam logic [7:0]  POS_TAG_S5  = 8'h05;
  // slot 0 tag bits and the slot 1 read/write bit
  localparam int          TAG_FRAME = 15;
  localparam int          TAG_ADDR  = 14;
  localparam int          TAG_DATA  = 13;
  localparam int          TAG_S5    = 10;
  localparam int          S1_RW     = 19;
  // link register indices
  localparam logic [6:0]  IDX_RESET = 7'h00;
  localparam logic [6:0]  IDX_MID   = 7'h3c;
  localparam logic [6:0]  IDX_MSTAT = 7'h3e;
  localparam logic [6:0]  IDX_RATE1 = 7'h40;
  localparam logic [6:0]  IDX_RATE2 = 7'h42;
  localparam logic [6:0]  IDX_WAKE  = 7'h52;
  localparam logic [6:0]  IDX_MISC  = 7'h56;
  // link register fields and defaults
  localparam int          HALT_BIT  = 12;
  localparam int          PWR_MSB   = 13;
  localparam int          PWR_LSB   = 8;
  localparam int          PWR_ADC1  = 2;
  localparam int          WAKE_RI1  = 1;
  localparam logic [5:0]  PWR_DEF   = 6'h3f;
  localparam logic [15:0] RATE_DEF  = 16'h0000;
  localparam logic [15:0] WAKE_DEF  = 16'h0000;
  localparam logic [15:0] MISC_DEF  = 16'h0000;
  localparam logic [15:0] MISC_MASK = 16'h1077;
  localparam logic [15:0] WAKE_MASK = 16'he83a;
  localparam logic [7:0]  READY_ALL = 8'h3f;
  // axi4-lite map
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_STAT  = 8'h04;
  localparam logic [7:0]  OFS_LAST  = 8'h08;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  typedef enum {ST_RUN, ST_HALT, ST_WAIT} aclk_link_st_t;
endpackage

// ===== core/aclk_sync2.sv
// Purpose: two-flop synchroniser for levels from outside the clock domain
// Assumes: inputs change slowly against clk_in
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module aclk_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// ===== core/aclk_clkgen.sv
// Purpose: bit clock divider with edge enables
// Assumes: HALF core cycles per bit clock half period
// Notes:   clock parks low at once when run drops
`timescale 1ns/10ps
module aclk_clkgen #(
  parameter int HALF = 6
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  output logic      bit_clk_out,
  output logic      rise_en_out,
  output logic      fall_en_out
);
  logic [7:0] cnt_r;
  logic       wrap;

  assign wrap = (cnt_r == 8'(HALF - 1));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r       <= 8'h00;
      bit_clk_out <= 1'b0;
      rise_en_out <= 1'b0;
      fall_en_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r       <= 8'h00;
      bit_clk_out <= 1'b0;
      rise_en_out <= 1'b0;
      fall_en_out <= 1'b0;
    end else begin
      cnt_r       <= wrap ? 8'h00 : cnt_r + 8'h01;
      bit_clk_out <= wrap ? !bit_clk_out : bit_clk_out;
      rise_en_out <= wrap && !bit_clk_out;
      fall_en_out <= wrap && bit_clk_out;
    end
  end
endmodule

// ===== dv/aclk_ctl_model.sv
// Purpose: ac-link controller model driving sync and serial out
// Assumes: bits change on bit clock rise, input sampled on fall
// Notes:   lines driven low between frames
`timescale 1ns/10ps
module aclk_ctl_model (
  // link
  input  wire logic bit_clk_in,
  input  wire logic sdata_in_in,
  output logic      sync_out,
  output logic      sdata_out_out
);
  logic [55:0] rx_r;
  initial begin
    sync_out = 1'b0;
    sdata_out_out = 1'b0;
    rx_r = '0;
  end
  // n bits only, so a halting frame stops at the decode fall
  task automatic frame(input logic [15:0] t, input logic [19:0] s1, input logic [19:0] s2,
                       input int n);
    logic [55:0] tx;
    tx = {t, s1, s2};
    for (int i = 0; i < n; i++) begin
      @(posedge bit_clk_in);
      sync_out <= (i < 16);
      sdata_out_out <= (i < 56) ? tx[55-i] : 1'b0;
      @(negedge bit_clk_in);
      if (i > 0 && i < 57) rx_r = {rx_r[54:0], sdata_in_in};
    end
    sync_out <= 1'b0;
    sdata_out_out <= 1'b0;
  endtask
  task automatic set_sync(input logic v);
    sync_out <= v;
  endtask
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench for the codec ac-link access and power block
// Assumes: controller model drives the link, axi4-lite master tasks here
// Notes:   real four-frame wait before sync kept, so the halt test is slow
`timescale 1ns/10ps
module tb;
  import aclk_pkg::*;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        lrst_n = 1'b0;
  logic        id_lo = 1'b0;
  logic        ring = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]  aa = '0;
  logic [31:0] wd = '0;
  logic        awr, wrdy, bv, arr, rv, bclk, sdi, sync, sdo;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  int          fail_count = 0;
  int          n_checks = 0;
  always #2.5 clk_in = ~clk_in;
  aclk_codec_access_power dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_reset_n_in(lrst_n), .sync_in(sync),
    .sdata_out_in(sdo), .bit_clk_out(bclk), .sdata_in_out(sdi),
    .codec_id_select_low_in(id_lo), .codec_id_select_high_in(1'b0), .ring_detect_in(ring),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(aa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(aa),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp));
  aclk_ctl_model ctl (.bit_clk_in(bclk), .sdata_in_in(sdi), .sync_out(sync),
                      .sdata_out_out(sdo));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // handshakes judged at the rising edge on pre-edge values, released by nba there
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, dn;
    @(posedge clk_in);
    aa <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    bry <= w;
    arv <= !w;
    rry <= !w;
    for (int n = 0; n < 64; n++) begin
      @(posedge clk_in);
      ta = awv && awr;
      tw = wv && wrdy;
      tr = arv && arr;
      dn = (bv && bry) || (rv && rry);
      rd = rdata;
      rs = w ? bresp : rresp;
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tr) arv <= 1'b0;
      if (dn) begin
        bry <= 1'b0;
        rry <= 1'b0;
        return;
      end
    end
    fail_count++;
    finish_test();
  endtask
  task automatic wr16(input logic [15:0] t, input logic [6:0] i, input logic [15:0] d);
    ctl.frame(t, {1'b0, i, 12'h000}, {d, 4'h0}, 256);
  endtask
  task automatic rd16(input logic [15:0] t, input logic [6:0] i, input logic [15:0] e);
    ctl.frame(t, {1'b1, i, 12'h000}, 20'h0, 256);
    ctl.frame(16'h8000, 20'h0, 20'h0, 256);
    chk(32'({ctl.rx_r[55:53], ctl.rx_r[42:40]}), 32'h38);
    chk(32'(ctl.rx_r[39:20]), 32'({1'b0, i, 12'h000}));
    chk(32'(ctl.rx_r[19:0]), 32'({e, 4'h0}));
  endtask
  task automatic bclk_low(input int n);
    repeat (n) begin
      @(negedge clk_in);
      chk(32'({bclk, sdi}), 32'h0);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    lrst_n <= 1'b1;
    ctl.frame(16'h8000, 20'h0, 20'h0, 256);
    ctl.frame(16'h8000, 20'h0, 20'h0, 256);
    chk(32'(ctl.rx_r[55]), 32'h0);
    axi(1'b1, OFS_CTRL, 32'h1);
    chk(32'(rs), 32'(RESP_OKAY));
    axi(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd[0]), 32'h1);
    axi(1'b0, 8'h10, 32'h0);
    chk({rd[29:0], rs}, 32'(RESP_SLV));
    $display("test setup done");
    wr16(16'he000, IDX_RATE1, 16'h1f40);
    rd16(16'hc000, IDX_RATE1, 16'h1f40);
    wr16(16'h6000, IDX_RATE1, 16'h1234);
    rd16(16'hc000, IDX_RATE1, 16'h1f40);
    $display("test primary done");
    wr16(16'he000, IDX_WAKE, 16'h0002);
    ctl.frame(16'he000, {1'b0, IDX_MISC, 12'h000}, 20'h10000, 56);
    repeat (10) @(posedge clk_in);
    bclk_low(100);
    axi(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd[1]), 32'h1);
    ring <= 1'b1;
    repeat (6) @(negedge clk_in);
    chk(32'(sdi), 32'h1);
    @(posedge clk_in);
    ring <= 1'b0;
    repeat (12300) @(posedge clk_in);
    ctl.set_sync(1'b1);
    bclk_low(230);
    @(posedge clk_in);
    ctl.set_sync(1'b0);
    for (int n = 0; n < 100 && bclk !== 1'b1; n++) @(negedge clk_in);
    chk(32'(bclk), 32'h1);
    rd16(16'hc000, IDX_RATE1, 16'h1f40);
    $display("test halt done");
    id_lo <= 1'b1;
    lrst_n <= 1'b0;
    repeat (10) @(posedge clk_in);
    lrst_n <= 1'b1;
    repeat (20) @(posedge clk_in);
    rd16(16'h8001, IDX_RATE1, 16'h0);
    wr16(16'h8001, IDX_RATE2, 16'habcd);
    axi(1'b0, OFS_LAST, 32'h0);
    chk(rd, 32'h0001abcd);
    wr16(16'h8002, IDX_RATE2, 16'h5555);
    wr16(16'he000, IDX_RATE2, 16'h7777);
    rd16(16'h8001, IDX_RATE2, 16'habcd);
    $display("test secondary done");
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    finish_test();
  end
endmodule
